// ==== verilog/afb_pkg.sv ====
// package: constants and carrier types for the flash bus host controller
// assumes a 20 MHz core clock; delays are given in ns and converted here
package afb_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    // default delay figures, in ns
    localparam int CE_ACCESS_NS = 120;
    localparam int OE_ACCESS_NS = 50;
    localparam int WE_PULSE_NS = 50;
    localparam int MIN_RESET_PULSE_NS = 500;
    localparam int RESET_RECOVERY_NS = 50;
    localparam int RESET_READY_NS = 20000;
    // cycle counts: least times round up
    localparam int CE_ACCESS_CYC =
        (CE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OE_ACCESS_CYC =
        (OE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_CYC =
        (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_RESET_PULSE_CYC =
        (MIN_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_RECOVERY_CYC =
        (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_READY_CYC =
        (RESET_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // host-side request
    typedef struct packed {
        logic read;
        logic write;
        logic flash_reset;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } afb_req_type;

    // pins towards the flash, active low controls except data_oe (active high)
    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_en_n;
        logic hw_reset_n;
        logic [ADDR_W-1:0] address_lines;
        logic [DATA_W-1:0] data_out;
        logic data_oe;
    } afb_pins_type;

    typedef enum logic [2:0] {
        ST_RESET, ST_RECOVER, ST_IDLE, ST_READ, ST_WRITE, ST_GAP
    } afb_state_type;
endpackage

// ==== verilog/afb_host.sv ====
// host controller driving an asynchronous byte-wide flash over its pins
// assumes flash pin inputs are synchronous to core_clk
`timescale 1ns/1ns
module afb_host
    import afb_pkg::*;
#(
    // delay figures in core_clk cycles
    parameter int CE_CYC = CE_ACCESS_CYC,
    parameter int WE_CYC = WE_PULSE_CYC,
    parameter int RP_CYC = MIN_RESET_PULSE_CYC,
    parameter int RH_CYC = RESET_RECOVERY_CYC,
    parameter int READY_CYC = RESET_READY_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // user request side
    input wire afb_req_type req,
    output logic req_ready,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic busy,
    // flash pins
    output afb_pins_type pins,
    input wire logic [DATA_W-1:0] data_lines_in,
    input wire logic ready_busy_n
);
    afb_state_type state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    afb_pins_type pins_reg, pins_next;
    logic [DATA_W-1:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic ready_reg, ready_next;
    logic busy_reg, busy_next;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = (n < 1) ? CNT_W'(1) : CNT_W'(n);
    endfunction

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pins_next = pins_reg;
        rd_data_next = rd_data_reg;
        rd_valid_next = 1'b0;
        ready_next = 1'b0;
        busy_next = busy_reg;
        if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
        case (state_reg)
            ST_RESET: begin
                // hold reset low, data released, no cycles
                pins_next.hw_reset_n = 1'b0;
                pins_next.chip_sel_n = 1'b1;
                pins_next.out_en_n = 1'b1;
                pins_next.write_en_n = 1'b1;
                pins_next.data_oe = 1'b0;
                if (cnt_reg == '0) begin
                    pins_next.hw_reset_n = 1'b1;
                    cnt_next = cyc(READY_CYC);
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // wait for ready and recovery time, or leave when the ready time runs out
                if (ready_busy_n
                    && cnt_reg <= cyc(READY_CYC) - cyc(RH_CYC)) begin
                    state_next = ST_IDLE;
                    busy_next = 1'b0;
                    ready_next = 1'b1;
                end else if (cnt_reg == '0) begin
                    state_next = ST_IDLE;
                    busy_next = 1'b0;
                    ready_next = 1'b1;
                end
            end
            ST_IDLE: begin
                // standby: chip select high, reset high
                pins_next.chip_sel_n = 1'b1;
                pins_next.out_en_n = 1'b1;
                pins_next.write_en_n = 1'b1;
                pins_next.data_oe = 1'b0;
                ready_next = 1'b1;
                if (req.flash_reset) begin
                    // restarting aborted work is up to the user
                    busy_next = 1'b1;
                    ready_next = 1'b0;
                    cnt_next = cyc(RP_CYC);
                    state_next = ST_RESET;
                end else if (req.read) begin
                    // read cycle; id and status reads too
                    pins_next.chip_sel_n = 1'b0;
                    pins_next.out_en_n = 1'b0;
                    pins_next.address_lines = req.addr;
                    busy_next = 1'b1;
                    ready_next = 1'b0;
                    cnt_next = cyc(CE_CYC);
                    state_next = ST_READ;
                end else if (req.write) begin
                    // command write; address holds sector bits
                    pins_next.chip_sel_n = 1'b0;
                    pins_next.write_en_n = 1'b0;
                    pins_next.address_lines = req.addr;
                    pins_next.data_out = req.wdata;
                    pins_next.data_oe = 1'b1;
                    busy_next = 1'b1;
                    ready_next = 1'b0;
                    cnt_next = cyc(WE_CYC);
                    state_next = ST_WRITE;
                end
            end
            ST_READ: begin
                if (cnt_reg == '0) begin
                    rd_data_next = data_lines_in;
                    rd_valid_next = 1'b1;
                    // release output enable; data floats
                    pins_next.out_en_n = 1'b1;
                    pins_next.chip_sel_n = 1'b1;
                    state_next = ST_GAP;
                end
            end
            ST_WRITE: begin
                if (cnt_reg == '0) begin
                    pins_next.write_en_n = 1'b1;
                    state_next = ST_GAP;
                end
            end
            ST_GAP: begin
                // device may keep working after deselect
                pins_next.chip_sel_n = 1'b1;
                pins_next.data_oe = 1'b0;
                busy_next = 1'b0;
                ready_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // power-up reset pulse puts device in read-array
            state_reg <= ST_RESET;
            cnt_reg <= CNT_W'(RP_CYC);
            pins_reg <= '{chip_sel_n: 1'b1, out_en_n: 1'b1,
                write_en_n: 1'b1, hw_reset_n: 1'b0,
                address_lines: '0, data_out: '0, data_oe: 1'b0};
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
            ready_reg <= 1'b0;
            busy_reg <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pins_reg <= pins_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            ready_reg <= ready_next;
            busy_reg <= busy_next;
        end
    end

    assign pins = pins_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign req_ready = ready_reg;
    assign busy = busy_reg;

    property p_read_pins;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_READ) |-> (!pins.chip_sel_n && !pins.out_en_n
            && pins.write_en_n && !pins.data_oe);
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("bad read pins");

    property p_write_pins;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_WRITE) |-> (!pins.chip_sel_n && !pins.write_en_n
            && pins.out_en_n && pins.data_oe);
    endproperty
    a_write_pins: assert property (p_write_pins)
        else $error("bad write");

    property p_reset_quiet;
        @(posedge core_clk) disable iff (!rst_n)
        !pins.hw_reset_n |-> (pins.chip_sel_n && !pins.data_oe);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("reset busy");

    property p_oe_float;
        @(posedge core_clk) disable iff (!rst_n)
        !pins.out_en_n |-> !pins.data_oe;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("data clash");

    // idle means deselected, reset released, data lines released
    property p_standby;
        @(posedge core_clk) disable iff (!rst_n)
        req_ready |-> (pins.chip_sel_n && pins.hw_reset_n && !pins.data_oe);
    endproperty
    a_standby: assert property (p_standby)
        else $error("not in standby");

    // read data is taken as output enable and select are released
    property p_read_release;
        @(posedge core_clk) disable iff (!rst_n)
        rd_valid |-> (pins.chip_sel_n && pins.out_en_n);
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("read not released");
endmodule

// ==== verification/afb_flash_model.sv ====
// behavioural byte-wide flash seen from the host's pins
// assumes pins change only just after core_clk rising edges
`timescale 1ns/1ns
module afb_flash_model
    import afb_pkg::*;
#(
    parameter int PROG_CYC = 30,
    parameter int RST_CYC = 15,
    parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] STATUS = 8'h3c
) (
    // clock and pins
    input wire logic core_clk,
    input wire afb_pins_type pins,
    output logic [DATA_W-1:0] data_lines_in,
    output logic ready_busy_n
);
    logic [7:0] mem [16];
    logic [7:0] last, drv, pd;
    logic [3:0] pa;
    logic id_mode = 0, arm = 0, pend = 0, we_q = 1;
    int busy_cnt = 0;
    wire sel = pins.hw_reset_n && !pins.chip_sel_n;
    initial for (int i = 0; i < 16; i++) mem[i] = 8'(i * 7 + 1);
    always @(posedge core_clk) begin
        we_q <= pins.write_en_n;
        if (!pins.hw_reset_n) begin
            id_mode <= 0;
            arm <= 0;
            pend <= 0;
            busy_cnt <= (busy_cnt > 0) ? RST_CYC : 0;
        end else begin
            if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
            if (busy_cnt == 1 && pend) mem[pa] <= pd;
            if (sel && !pins.write_en_n && we_q && pins.out_en_n) begin
                arm <= 0;
                if (arm) begin
                    pa <= pins.address_lines[3:0];
                    pd <= pins.data_out;
                    pend <= 1;
                    busy_cnt <= PROG_CYC;
                end else if (pins.data_out == 8'h90) id_mode <= 1;
                else if (pins.data_out == 8'hf0) id_mode <= 0;
                else if (pins.data_out == 8'ha0) arm <= 1;
            end
        end
        if (sel && !pins.out_en_n) last <= drv;
    end
    assign ready_busy_n = (busy_cnt == 0);
    assign drv = id_mode ? ID_CODE : (busy_cnt > 0) ? STATUS :
        mem[pins.address_lines[3:0]];
    assign data_lines_in = (sel && !pins.out_en_n) ? drv :
        ~last;
endmodule

// ==== verification/tb_afb_host.sv ====
// self-checking bench for the flash bus host controller
// assumes the behavioural flash model beside it
`timescale 1ns/1ns
module tb_afb_host;
    import afb_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
    localparam logic [7:0] ST_VAL = 8'h3c;
    logic core_clk, rst_n, clk_en, req_ready, rd_valid, busy, ready_busy_n;
    logic [DATA_W-1:0] rd_data, data_lines_in;
    afb_req_type req;
    afb_pins_type pins;
    int err_count = 0;
    int checks = 0;
    afb_host #(.READY_CYC(20)) u_afb_host(.core_clk(core_clk),
        .rst_n(rst_n), .clk_en(clk_en), .req(req), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .pins(pins),
        .data_lines_in(data_lines_in), .ready_busy_n(ready_busy_n));
    afb_flash_model #(.ID_CODE(ID_VAL), .STATUS(ST_VAL)) u_afb_flash_model(
        .core_clk(core_clk), .pins(pins), .data_lines_in(data_lines_in),
        .ready_busy_n(ready_busy_n));
    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [7:0] mv(int i);
        return 8'(i * 7 + 1);
    endfunction
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s exp %h got %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic go(logic r, logic w, logic f, logic [20:0] a,
        logic [7:0] d);
        int n;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 200) chk("req_ready", 8'h1, 8'(req_ready));
        @(posedge core_clk);
        req <= '{r, w, f, a, d};
        @(posedge core_clk);
        req <= '0;
    endtask
    task automatic rd(logic [20:0] a, logic [7:0] exp);
        int n;
        go(1, 0, 0, a, 8'h00);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            if (n == 1) begin
                chk("rd pins", 8'h2, 8'({pins.chip_sel_n, pins.out_en_n,
                    pins.write_en_n, pins.data_oe}));
                chk("rd addr", a[7:0], pins.address_lines[7:0]);
                chk("rd busy", 8'h1, 8'(busy));
            end
        end while (rd_valid !== 1'b1 && n < 40);
        chk("rd time", 8'(CE_ACCESS_CYC + 1), 8'(n));
        chk("rd data", exp, rd_data);
        chk("rd release", 8'h3, 8'({pins.chip_sel_n,
            pins.out_en_n}));
    endtask
    task automatic wr(logic [20:0] a, logic [7:0] d);
        go(0, 1, 0, a, d);
        @(posedge core_clk);
        #1;
        chk("wr pins", 8'h5, 8'({pins.chip_sel_n, pins.out_en_n,
            pins.write_en_n, pins.data_oe}));
        chk("wr data", d, pins.data_out);
        chk("wr addr", a[7:0], pins.address_lines[7:0]);
        repeat (2) @(posedge core_clk);
        #1;
        chk("wr end pins", 8'he, 8'({pins.chip_sel_n, pins.out_en_n,
            pins.write_en_n, pins.data_oe}));
        chk("wr ready", 8'h1, 8'(req_ready));
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (ready_busy_n !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("ready_busy_n", 8'h1, 8'(ready_busy_n));
    endtask
    task automatic t_array();
        rd(3, mv(3));
        rd(15, mv(15));
        $display("array read done");
    endtask
    task automatic t_freeze();
        int n;
        go(1, 0, 0, 2, 8'h00);
        clk_en <= 1'b0;
        repeat (5) @(posedge core_clk);
        clk_en <= 1'b1;
        n = 5;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (rd_valid !== 1'b1 && n < 40);
        chk("frozen rd time", 8'(CE_ACCESS_CYC + 6), 8'(n));
        chk("frozen rd data", mv(2), rd_data);
        $display("clock enable done");
    endtask
    task automatic t_ident();
        wr(0, 8'h90);
        rd(1, ID_VAL);
        wr(0, 8'hf0);
        rd(1, mv(1));
        $display("ident done");
    endtask
    task automatic t_prog();
        wr(0, 8'ha0);
        wr(5, 8'h99);
        rd(5, ST_VAL);
        wait_rdy();
        rd(5, 8'h99);
        $display("program done");
    endtask
    task automatic t_hwreset();
        int n;
        wr(0, 8'ha0);
        wr(6, 8'h77);
        go(0, 0, 1, 0, 8'h00);
        n = 0;
        while (pins.hw_reset_n !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("reset pin", 8'h0, 8'(pins.hw_reset_n));
        chk("busy in reset", 8'h0, 8'(ready_busy_n));
        n = 0;
        while (pins.hw_reset_n !== 1'b1 && n < 40) begin
            chk("quiet in reset", 8'h2, 8'({pins.chip_sel_n,
                pins.data_oe}));
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("reset pulse", 8'(MIN_RESET_PULSE_CYC), 8'(n));
        rd(6, mv(6));
        wr(0, 8'ha0);
        wr(6, 8'h77);
        wait_rdy();
        rd(6, 8'h77);
        $display("hw reset done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        rst_n = 0;
        clk_en = 1;
        req = '0;
        repeat (8) @(posedge core_clk);
        #1;
        chk("reset pins", 8'h2, 8'({pins.hw_reset_n, busy,
            req_ready}));
        @(posedge core_clk);
        rst_n <= 1'b1;
        t_array();
        t_freeze();
        t_ident();
        t_prog();
        t_hwreset();
        end_of_test();
    end
endmodule
